// File: hdl/ocp_serial_port.sv
`timescale 1ns/1ns
// Functional notes
// - runtime write 10111: data bit 15 low-power request, bit 14 global reset.
// - runtime write bit 9 routes both channels to the internal test bus.
// - runtime write bit 8 disables and bypasses the output buffer.
// - extended commands: load 11111, burn 11001, read 01111, analog read 01001.
// - fuse bit 11 selects true or inverted sine and cosine outputs.
// - fuse bit 10 selects differential or common level on sine negative pin.
// - fuse bit 9 selects differential or common level on cosine negative pin.
// - fuse bits 8:7 are the two-bit amplifier gain code.
// - fuse bit 6 selects output bias 1.5V (0) or 2.5V (1).
// - fuse bits 5:0 are the six-bit hall bias current code.
// - extended mode: each data bit lasts four interface clocks.
// - device holds a 46-bit fuse word programmable through the port.
// - fuse bits 44 and 45 reserved for fuse test and protection.
// - fuse bit 13 locks factory trim bits against change.
// - normal frame: five command bits msb first, then 16 data bits.
// - interface held in reset while chip select low; access starts on its rise.
// - command bit 4 read/write, bit 3 normal/extended timing.
// - extended frame: five command bits then 46 data bits msb first.
module ocp_serial_port
   import ocp_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        chip_select,
   input  wire logic        interface_clock,
   input  wire logic        serial_data_line_in,
   output logic             serial_data_line_out,
   output logic             serial_data_line_oe,
   output logic             low_power_request,
   output logic             global_reset_pulse,
   output logic             test_bus_route,
   output logic             output_buffer_skip,
   output ocp_user_s        user_cfg,
   output logic             fuse_burn_strobe,
   output logic             fuse_analog_readback_active,
   output logic [5:0]       fuse_analog_bit_index,
   output logic [45:0]      fuse_word
);

   // ----------------------------------------------------------------
   // pin synchronisers and edge find
   // ----------------------------------------------------------------
   logic [1:0] cs_sync;
   logic [1:0] ck_sync;
   logic [1:0] di_sync;
   logic       ck_prev;
   logic       cs_prev;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         cs_sync <= 2'h0;
         ck_sync <= 2'h0;
         di_sync <= 2'h0;
         ck_prev <= 1'b0;
         cs_prev <= 1'b0;
      end else begin
         cs_sync <= {cs_sync[0], chip_select};
         ck_sync <= {ck_sync[0], interface_clock};
         di_sync <= {di_sync[0], serial_data_line_in};
         ck_prev <= ck_sync[1];
         cs_prev <= cs_sync[1];
      end
   end

   logic cs_on;
   logic ck_rise;
   logic ck_fall;
   logic din;
   assign cs_on   = cs_sync[1];
   assign ck_rise = ck_sync[1] & ~ck_prev;
   assign ck_fall = ~ck_sync[1] & ck_prev;
   assign din     = di_sync[1];

   // ----------------------------------------------------------------
   // frame sequencer
   // ----------------------------------------------------------------
   ocp_state_e state;
   logic [4:0]  cmd;
   logic [2:0]  cmd_cnt;
   logic [5:0]  bit_cnt;
   logic [1:0]  sub_cnt;
   logic [45:0] shreg;
   logic [45:0] rd_shift;
   logic        unlocked;

   logic is_ext;
   logic is_read;
   logic [5:0] data_len;
   logic       last_sub;
   assign is_ext   = cmd[CMD_EXT_POS];
   assign is_read  = ~cmd[CMD_RW_POS];
   assign data_len = is_ext ? 6'(EXT_BITS) : 6'(NORM_BITS);
   assign last_sub = ~is_ext | (sub_cnt == 2'(EXT_CLK_PER_BIT - 1));

   logic frame_end;
   assign frame_end = (state == ST_DATA) && ck_rise && last_sub && (bit_cnt == data_len - 6'h1);

   always_ff @(posedge clk) begin
      if (!nrst || !cs_on) begin
         state   <= ST_IDLE;
         cmd     <= 5'h0;
         cmd_cnt <= 3'h0;
         bit_cnt <= 6'h0;
         sub_cnt <= 2'h0;
         shreg   <= 46'h0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (!cs_prev) begin
                  state <= ST_CMD;
               end
            end
            ST_CMD: begin
               if (ck_rise) begin
                  cmd     <= {cmd[3:0], din};
                  cmd_cnt <= cmd_cnt + 3'h1;
                  if (cmd_cnt == 3'(CMD_BITS - 1)) begin
                     state <= ST_DATA;
                  end
               end
            end
            ST_DATA: begin
               if (ck_rise) begin
                  sub_cnt <= last_sub ? 2'h0 : sub_cnt + 2'h1;
                  if (last_sub) begin
                     shreg   <= {shreg[44:0], din};
                     bit_cnt <= bit_cnt + 6'h1;
                     if (frame_end) begin
                        state <= ST_DONE;
                     end
                  end
               end
            end
            ST_DONE: state <= ST_DONE;
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // unlock tracking
   // ----------------------------------------------------------------
   logic wr_norm_done;
   logic wr_ext_done;
   logic [45:0] ext_word;
   assign wr_norm_done = frame_end && !is_read && !is_ext;
   assign wr_ext_done  = frame_end && !is_read && is_ext;
   assign ext_word     = {shreg[44:0], din};

   // kept across chip select low: unlock and fuse access are separate frames
   always_ff @(posedge clk) begin
      if (!nrst) begin
         unlocked <= 1'b0;
      end else if (wr_norm_done && {cmd} == CMD_FUSE_UNLOCK && ext_word[15:0] == UNLOCK_PATTERN) begin
         unlocked <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // runtime setup
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         low_power_request  <= 1'b0;
         global_reset_pulse <= 1'b0;
         test_bus_route     <= 1'b0;
         output_buffer_skip <= 1'b0;
      end else begin
         global_reset_pulse <= 1'b0;
         if (wr_norm_done && cmd == CMD_RUNTIME_SETUP) begin
            low_power_request  <= ext_word[RS_SLEEP_POS];
            global_reset_pulse <= ext_word[RS_GRST_POS];
            test_bus_route     <= ext_word[RS_TESTBUS_POS];
            output_buffer_skip <= ext_word[RS_OBSKIP_POS];
         end
      end
   end

   // ----------------------------------------------------------------
   // fuse word: load, burn, lock
   // ----------------------------------------------------------------
   logic [45:0] burned;
   logic [45:0] next_fuse;

   always_comb begin
      next_fuse = fuse_word;
      // user field always writable; reserved test bits never
      next_fuse[FW_USER_MSB:0] = ext_word[FW_USER_MSB:0];
      if (!burned[FW_LOCK_POS]) begin
         next_fuse[FW_TRIM_MSB:FW_LOCK_POS] = ext_word[FW_TRIM_MSB:FW_LOCK_POS];
      end
      next_fuse[FW_TEST_MSB:FW_TEST_LSB] = fuse_word[FW_TEST_MSB:FW_TEST_LSB];
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         fuse_word        <= FUSE_RESET;
         burned           <= FUSE_RESET;
         fuse_burn_strobe <= 1'b0;
      end else begin
         fuse_burn_strobe <= 1'b0;
         if (wr_ext_done && unlocked) begin
            if (cmd == CMD_FUSE_LOAD) begin
               fuse_word <= next_fuse;
            end else if (cmd == CMD_FUSE_BURN) begin
               fuse_word        <= next_fuse;
               burned           <= burned | next_fuse;
               fuse_burn_strobe <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         user_cfg <= '0;
      end else begin
         user_cfg <= ocp_decode_user(fuse_word);
      end
   end

   // ----------------------------------------------------------------
   // read path: data driven after falling edge, sampled on rising
   // ----------------------------------------------------------------
   logic rd_active;
   assign rd_active = (state == ST_DATA) && is_read;

   always_ff @(posedge clk) begin
      if (!nrst || !cs_on) begin
         rd_shift                    <= 46'h0;
         serial_data_line_out        <= 1'b0;
         serial_data_line_oe         <= 1'b0;
         fuse_analog_readback_active <= 1'b0;
         fuse_analog_bit_index       <= 6'h0;
      end else begin
         if (state == ST_CMD && ck_rise && cmd_cnt == 3'(CMD_BITS - 1)) begin
            rd_shift <= fuse_word;
         end else if (rd_active && ck_rise && last_sub) begin
            rd_shift <= {rd_shift[44:0], 1'b0};
         end
         if (rd_active && ck_fall) begin
            serial_data_line_oe  <= (cmd == CMD_FUSE_READ) || !is_ext;
            serial_data_line_out <= is_ext ? rd_shift[EXT_BITS-1] : rd_shift[NORM_BITS-1];
         end else if (!rd_active) begin
            serial_data_line_oe <= 1'b0;
         end
         fuse_analog_readback_active <= rd_active && cmd == CMD_FUSE_ANALOG_READ;
         fuse_analog_bit_index       <= 6'(EXT_BITS - 1) - bit_cnt;
      end
   end

endmodule

// File: hdl/ocp_pkg.sv
package ocp_pkg;
   // ----------------------------------------------------------------
   // frame layout
   // ----------------------------------------------------------------
   localparam int CMD_BITS       = 5;
   localparam int NORM_BITS      = 16;
   localparam int EXT_BITS       = 46;
   localparam int EXT_CLK_PER_BIT = 4;
   localparam int CMD_RW_POS     = 4;
   localparam int CMD_EXT_POS    = 3;

   // ----------------------------------------------------------------
   // command codes
   // ----------------------------------------------------------------
   localparam logic [4:0] CMD_RUNTIME_SETUP     = 5'h17;
   localparam logic [4:0] CMD_FUSE_UNLOCK       = 5'h10;
   localparam logic [4:0] CMD_FUSE_LOAD         = 5'h1f;
   localparam logic [4:0] CMD_FUSE_BURN         = 5'h19;
   localparam logic [4:0] CMD_FUSE_READ         = 5'h0f;
   localparam logic [4:0] CMD_FUSE_ANALOG_READ  = 5'h09;
   localparam logic [15:0] UNLOCK_PATTERN       = 16'h8cae;

   // ----------------------------------------------------------------
   // runtime setup fields
   // ----------------------------------------------------------------
   localparam int RS_SLEEP_POS  = 15;
   localparam int RS_GRST_POS   = 14;
   localparam int RS_TESTBUS_POS = 9;
   localparam int RS_OBSKIP_POS = 8;

   // ----------------------------------------------------------------
   // fuse word fields
   // ----------------------------------------------------------------
   localparam int FW_INVERT_POS = 11;
   localparam int FW_CMSIN_POS  = 10;
   localparam int FW_CMCOS_POS  = 9;
   localparam int FW_GAIN_LSB   = 7;
   localparam int FW_GAIN_W     = 2;
   localparam int FW_BIAS_POS   = 6;
   localparam int FW_HALL_LSB   = 0;
   localparam int FW_HALL_W     = 6;
   localparam int FW_LOCK_POS   = 13;
   localparam int FW_USER_MSB   = 12;
   localparam int FW_TRIM_LSB   = 14;
   localparam int FW_TRIM_MSB   = 43;
   localparam int FW_TEST_LSB   = 44;
   localparam int FW_TEST_MSB   = 45;
   localparam logic [45:0] FUSE_RESET = 46'h0;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       low_power_request;
      logic       global_reset;
      logic       test_bus_route;
      logic       output_buffer_skip;
   } ocp_runtime_s;

   typedef struct packed {
      logic       invert_channel;
      logic       sine_common_level_out;
      logic       cosine_common_level_out;
      logic [1:0] amp_gain;
      logic       output_bias_select;
      logic [5:0] hall_bias;
   } ocp_user_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CMD  = 3'b001,
      ST_DATA = 3'b010,
      ST_DONE = 3'b011
   } ocp_state_e;

   function automatic ocp_user_s ocp_decode_user(input logic [45:0] w);
      ocp_user_s u;
      u.invert_channel          = w[FW_INVERT_POS];
      u.sine_common_level_out   = w[FW_CMSIN_POS];
      u.cosine_common_level_out = w[FW_CMCOS_POS];
      u.amp_gain                = w[FW_GAIN_LSB +: FW_GAIN_W];
      u.output_bias_select      = w[FW_BIAS_POS];
      u.hall_bias               = w[FW_HALL_LSB +: FW_HALL_W];
      return u;
   endfunction
endpackage

// File: tb/ocp_host_model.sv
`timescale 1ns/1ns
module ocp_host_model (
   output logic      chip_select,
   output logic      interface_clock,
   output logic      host_data,
   output logic      host_oe,
   input  wire logic line
);
   initial begin
      chip_select = 1'b0;
      interface_clock = 1'b0;
      host_data = 1'b1;
      host_oe = 1'b0;
   end
   // link clock only runs inside frames; bit taken on the rise
   task automatic tick(output logic s);
      #62 interface_clock <= 1'b1;
      #1 s = line;
      #62 interface_clock <= 1'b0;
   endtask
   task automatic xfer(input logic [4:0] cmd, input logic [45:0] wd, input int n, output logic [45:0] rd);
      int   reps;
      logic s;
      reps = cmd[3] ? 4 : 1;
      rd = '0;
      chip_select <= 1'b1;
      host_oe <= 1'b1;
      #100;
      for (int i = 4; i >= 0; i--) begin
         host_data <= cmd[i];
         tick(s);
      end
      if (!cmd[4]) host_oe <= 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         for (int r = 0; r < reps; r++) begin
            host_data <= wd[i];
            tick(rd[i]);
         end
      end
      #200 chip_select <= 1'b0;
      host_oe <= 1'b0;
      #300;
   endtask
endmodule

// File: tb/ocp_serial_port_asserts.sv
`timescale 1ns/1ns
module ocp_serial_port_asserts
   import ocp_pkg::*;
(
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        chip_select,
   input wire logic        serial_data_line_oe,
   input wire logic        low_power_request,
   input wire logic        global_reset_pulse,
   input wire logic        test_bus_route,
   input wire logic        output_buffer_skip,
   input wire ocp_user_s   user_cfg,
   input wire logic        fuse_burn_strobe,
   input wire logic        fuse_analog_readback_active,
   input wire logic [5:0]  fuse_analog_bit_index,
   input wire logic [45:0] fuse_word
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   property p_cs_float; !chip_select [*5] |-> !serial_data_line_oe; endproperty
   a_cs_float: assert property (p_cs_float) else $error("line driven, cs low");
   property p_grst; global_reset_pulse |=> !global_reset_pulse; endproperty
   a_grst: assert property (p_grst) else $error("reset pulse too long");
   property p_burn; fuse_burn_strobe |=> !fuse_burn_strobe; endproperty
   a_burn: assert property (p_burn) else $error("burn pulse too long");
   property p_test; $stable(fuse_word[45:44]); endproperty
   a_test: assert property (p_test) else $error("test bits changed");
   property p_hall; user_cfg.hall_bias == $past(fuse_word[5:0]); endproperty
   a_hall: assert property (p_hall) else $error("hall bias");
   property p_gain; user_cfg.amp_gain == $past(fuse_word[8:7]); endproperty
   a_gain: assert property (p_gain) else $error("gain");
   property p_bias; user_cfg.output_bias_select == $past(fuse_word[6]); endproperty
   a_bias: assert property (p_bias) else $error("bias");
   property p_inv; user_cfg.invert_channel == $past(fuse_word[11]); endproperty
   a_inv: assert property (p_inv) else $error("invert");
   property p_cm;
      {user_cfg.sine_common_level_out, user_cfg.cosine_common_level_out} == $past(fuse_word[10:9]);
   endproperty
   a_cm: assert property (p_cm) else $error("common level");
   property p_rt;
      ($changed(low_power_request) || $changed(test_bus_route) || $changed(output_buffer_skip))
         |-> $past(chip_select, 2);
   endproperty
   a_rt: assert property (p_rt) else $error("runtime bit outside frame");
   property p_hold; !chip_select [*5] |-> $stable(fuse_word); endproperty
   a_hold: assert property (p_hold) else $error("fuse word moved");
   property p_idx;
      fuse_analog_readback_active |-> (fuse_analog_bit_index <= 6'h2d) && !serial_data_line_oe;
   endproperty
   a_idx: assert property (p_idx) else $error("bit index");
   c_grst: cover property (global_reset_pulse);
   c_oe: cover property (serial_data_line_oe);
   c_ana: cover property (fuse_analog_readback_active);
endmodule
bind ocp_serial_port ocp_serial_port_asserts chk (.*);

// File: tb/ocp_tb.sv
`timescale 1ns/1ns
module tb
   import ocp_pkg::*;
;
   logic        clk;
   logic        nrst;
   wire logic   cs, iclk, h_data, h_oe, d_out, d_oe, lp, grst, tbr, obs, burn, ana;
   ocp_user_s   ucfg;
   logic [5:0]  aidx;
   logic [45:0] fw;
   logic [45:0] rd;
   wire logic   line = d_oe ? d_out : (h_oe ? h_data : 1'b1);
   int          miscompares = 0, checks_done = 0, cycles = 0, grst_n = 0, burn_n = 0, ana_n = 0, oe_n = 0;

   ocp_host_model host (.chip_select(cs), .interface_clock(iclk), .host_data(h_data), .host_oe(h_oe), .line(line));
   ocp_serial_port dut (.clk(clk), .nrst(nrst), .chip_select(cs), .interface_clock(iclk),
      .serial_data_line_in(line), .serial_data_line_out(d_out), .serial_data_line_oe(d_oe),
      .low_power_request(lp), .global_reset_pulse(grst), .test_bus_route(tbr), .output_buffer_skip(obs),
      .user_cfg(ucfg), .fuse_burn_strobe(burn), .fuse_analog_readback_active(ana),
      .fuse_analog_bit_index(aidx), .fuse_word(fw));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (grst === 1'b1) grst_n++;
      if (burn === 1'b1) burn_n++;
      if (ana === 1'b1) ana_n++;
      if (d_oe === 1'b1) oe_n++;
      if (cycles == 40000) begin
         miscompares++;
         test_done();
      end
   end
   // ----
   // checking
   // ----
   task automatic check(input logic [45:0] seen, input logic [45:0] exp, input string m);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask
   task automatic test_done();
      if (miscompares == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // ----
   // scenarios
   // ----
   task automatic t_reset();
      check(46'({lp, grst, tbr, obs, burn, ana, d_oe}), '0, "outputs after reset");
      check(fw, '0, "fuse word after reset");
      check(46'(ucfg), '0, "user cfg after reset");
   endtask
   task automatic t_runtime();
      host.xfer(CMD_RUNTIME_SETUP, 46'hc300, 16, rd);
      repeat (4) @(posedge clk);
      check(46'({lp, tbr, obs}), 46'h7, "runtime set");
      check(46'(grst_n), 46'h1, "reset pulse count");
      host.xfer(5'h15, 46'hffff, 16, rd);
      host.xfer(CMD_RUNTIME_SETUP, 46'h0100, 16, rd);
      repeat (4) @(posedge clk);
      check(46'({lp, tbr, obs}), 46'h1, "runtime clear");
      check(46'(grst_n), 46'h1, "stray reset pulse");
   endtask
   task automatic t_fuse();
      host.xfer(CMD_FUSE_LOAD, 46'h0b9a, 46, rd);
      check(fw, '0, "load taken without unlock");
      host.xfer(CMD_FUSE_UNLOCK, 46'h8cad, 16, rd);
      host.xfer(CMD_FUSE_BURN, 46'h0b9a, 46, rd);
      check(46'(burn_n), '0, "burn without unlock");
      check(fw, '0, "fuse word moved without unlock");
      host.xfer(CMD_FUSE_UNLOCK, 46'(UNLOCK_PATTERN), 16, rd);
      host.xfer(CMD_FUSE_LOAD, 46'h0b9a, 46, rd);
      repeat (4) @(posedge clk);
      check(fw, 46'h0b9a, "fuse load");
      check(46'(ucfg.amp_gain), 46'h3, "gain field");
      check(46'(ucfg.hall_bias), 46'h1a, "hall bias field");
      check(46'({ucfg.invert_channel, ucfg.sine_common_level_out, ucfg.cosine_common_level_out,
                 ucfg.output_bias_select}), 46'ha, "polarity, common level, bias after load");
      host.xfer(CMD_FUSE_BURN, 46'h0465, 46, rd);
      repeat (4) @(posedge clk);
      check(fw, 46'h0465, "fuse burn");
      check(46'(burn_n), 46'h1, "burn strobe count");
      check(46'(ucfg.amp_gain), 46'h0, "gain field after burn");
      check(46'(ucfg.hall_bias), 46'h25, "hall bias field after burn");
      check(46'({ucfg.invert_channel, ucfg.sine_common_level_out, ucfg.cosine_common_level_out,
                 ucfg.output_bias_select}), 46'h5, "polarity, common level, bias after burn");
   endtask
   task automatic t_reads();
      host.xfer(5'h00, '0, 16, rd);
      check(rd, 46'h0465, "normal read");
      host.xfer(CMD_FUSE_READ, '0, 46, rd);
      check(rd, 46'h0465, "extended read");
      check(46'(oe_n > 100), 46'h1, "device never drove");
      host.xfer(CMD_FUSE_ANALOG_READ, '0, 46, rd);
      check(46'(ana_n > 2000), 46'h1, "analog readback flag");
   endtask

   initial begin
      nrst = 1'b0;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      t_reset();
      t_runtime();
      t_fuse();
      t_reads();
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      t_reset();
      test_done();
   end
endmodule
